// ### hdl/mcuid_regs.svh
`ifndef MCUID_REGS_SVH
`define MCUID_REGS_SVH
// Special function register file addresses.
`define MCUID_ADDR_INDF 7'h00
`define MCUID_ADDR_TIMER 7'h01
`define MCUID_ADDR_PCL 7'h02
`define MCUID_ADDR_STATUS 7'h03
`define MCUID_ADDR_PORT 7'h06
`define MCUID_ADDR_PC_HIGH_HOLDING_LATCH 7'h0a
`define MCUID_ADDR_DIR 7'h06
// Status bit positions.
`define MCUID_ST_C 0
`define MCUID_ST_DC 1
`define MCUID_ST_Z 2
`define MCUID_ST_PD 3
`define MCUID_ST_TO 4
// Reset values.
`define MCUID_STATUS_RST 8'h18
`define MCUID_DIR_RST 8'hff
// Control word that copies W into the direction register.
`define MCUID_DIR_LOAD_INSTR 14'h0066
// Input-only pin position in the direction register.
`define MCUID_INPUT_ONLY_BIT 3
// Oscillator periods per instruction cycle.
`define MCUID_OSC_PER_CYCLE 4
`endif

// ### hdl/mcuid_pkg.sv
package mcuid_pkg;
    // Execution state of the core: normal execute or forced no-operation.
    typedef enum logic [0:0] {
        MCUID_EXEC = 1'b0,
        MCUID_FLUSH = 1'b1
    } mcuid_state_t;
    // Operation class produced by the decoder.
    typedef enum logic [4:0] {
        OP_NOP, OP_MOVWF, OP_CLR, OP_SUB_W_FILE, OP_DECREMENT_FILE, OP_OR_W_FILE, OP_ANDWF, OP_XOR_W_FILE,
        OP_ADD_W_FILE, OP_MOVF, OP_COMPLEMENT_FILE, OP_INCREMENT_FILE, OP_DEC_SKIP_ZERO, OP_RRF, OP_RLF, OP_SWAPF,
        OP_INC_SKIP_ZERO, OP_BCF, OP_BSF, OP_TEST_SKIP_CLEAR, OP_TEST_SKIP_SET, OP_MOVE_LITERAL, OP_RETURN_WITH_LITERAL, OP_OR_LITERAL,
        OP_ANDLW, OP_XOR_LITERAL, OP_SUB_LITERAL, OP_ADD_LITERAL, OP_CALL, OP_JUMP_OP, OP_RETURN, OP_SLEEP_WDT
    } mcuid_op_t;
endpackage : mcuid_pkg

// ### hdl/mcuid_decode.sv
`timescale 1ns/100ps
// Pure decoder of a 14-bit instruction word into an operation class.
module mcuid_decode
    import mcuid_pkg::*;
(
    input wire logic [13:0] i_instr,
    output mcuid_pkg::mcuid_op_t o_op,
    output logic o_is_watchdog_clear_op
);
    // Byte-oriented opcodes sit in bits 11:8, bit forms in 13:10, literal forms in 13:10, 13:9 or 13:8.
    always_comb begin
        o_is_watchdog_clear_op = (i_instr == 14'h0064);
        o_op = OP_NOP;
        case (i_instr[13:12])
            2'b00: begin
                case (i_instr[11:8])
                    4'h0: begin
                        if (i_instr[7]) begin
                            o_op = OP_MOVWF;
                        end else if (i_instr[6:0] == 7'h08 || i_instr[6:0] == 7'h09) begin
                            o_op = OP_RETURN;
                        end else if (i_instr[6:0] == 7'h63 || i_instr[6:0] == 7'h64) begin
                            o_op = OP_SLEEP_WDT;
                        end else begin
                            o_op = OP_NOP;
                        end
                    end
                    4'h1: o_op = OP_CLR;
                    4'h2: o_op = OP_SUB_W_FILE;
                    4'h3: o_op = OP_DECREMENT_FILE;
                    4'h4: o_op = OP_OR_W_FILE;
                    4'h5: o_op = OP_ANDWF;
                    4'h6: o_op = OP_XOR_W_FILE;
                    4'h7: o_op = OP_ADD_W_FILE;
                    4'h8: o_op = OP_MOVF;
                    4'h9: o_op = OP_COMPLEMENT_FILE;
                    4'ha: o_op = OP_INCREMENT_FILE;
                    4'hb: o_op = OP_DEC_SKIP_ZERO;
                    4'hc: o_op = OP_RRF;
                    4'hd: o_op = OP_RLF;
                    4'he: o_op = OP_SWAPF;
                    default: o_op = OP_INC_SKIP_ZERO;
                endcase
            end
            2'b01: begin
                case (i_instr[11:10])
                    2'b00: o_op = OP_BCF;
                    2'b01: o_op = OP_BSF;
                    2'b10: o_op = OP_TEST_SKIP_CLEAR;
                    default: o_op = OP_TEST_SKIP_SET;
                endcase
            end
            2'b10: o_op = i_instr[11] ? OP_JUMP_OP : OP_CALL;
            default: begin
                if (i_instr[11:10] == 2'b00) begin
                    o_op = OP_MOVE_LITERAL;
                end else if (i_instr[11:10] == 2'b01) begin
                    o_op = OP_RETURN_WITH_LITERAL;
                end else if (i_instr[11:9] == 3'b110) begin
                    o_op = OP_SUB_LITERAL;
                end else if (i_instr[11:9] == 3'b111) begin
                    o_op = OP_ADD_LITERAL;
                end else if (i_instr[11:8] == 4'h8) begin
                    o_op = OP_OR_LITERAL;
                end else if (i_instr[11:8] == 4'h9) begin
                    o_op = OP_ANDLW;
                end else begin
                    o_op = OP_XOR_LITERAL;
                end
            end
        endcase
    end
endmodule : mcuid_decode

// ### hdl/mcuid_core.sv
`timescale 1ns/100ps
`include "mcuid_regs.svh"
// Behaviour
// - Status writes still get instruction's Z/C/DC.
// - Direction register bit 3 reads one.
// - Reading low PC byte gives current PC.
// - Writing low byte loads latch into high.
// - Modify low byte uses current PC operand.
// - Bit ops read, change one bit, write.
// - Port self-modify uses pin levels.
// - Timer-count write clears assigned prescaler.
// - Branches and true tests take two cycles.
// - AND/OR/XOR/COMPLEMENT_FILE one cycle, only zero flag.
// - Adds and subtracts update C, DC, Z.
// - Skip forms skip on zero, no flags.
// - Rotates go through carry only.
// - Bit ops decode index and address.
// - Literal OR/XOR set W, zero only.
// - Return-with-literal two cycles; move-literal one.
// - Standby and watchdog clear update TO, PD.
// - Destination bit picks W or file.
// - Instruction cycle is four oscillator periods.
module mcuid_core
    import mcuid_pkg::*;
#(
    parameter int PC_W = 11,
    parameter int STACK_DEPTH = 8
) (
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    input wire logic I_CE,
    input wire logic [13:0] I_INSTR,
    input wire logic [7:0] I_PORT_PINS,
    input wire logic I_PRESCALER_ON_TIMER,
    input wire logic [7:0] I_FILE_RDATA,
    output logic [PC_W-1:0] O_PC,
    output logic [6:0] O_FILE_ADDR,
    output logic [7:0] O_FILE_WDATA,
    output logic O_FILE_WE,
    output logic [7:0] O_W,
    output logic [7:0] O_STATUS,
    output logic [7:0] O_PORT_LATCH,
    output logic [7:0] O_PORT_DIR,
    output logic [7:0] O_TIMER,
    output logic O_PRESCALER_CLR,
    output logic O_WDT_CLR,
    output logic O_SLEEP,
    output logic O_INSTR_CYCLE,
    output logic O_FLUSH
);
    import mcuid_pkg::*;

    initial begin
        if (PC_W < 9 || PC_W > 13 || STACK_DEPTH < 1 || STACK_DEPTH > 16) begin
            $error("mcuid_core: unsupported parameter values");
        end
    end

    mcuid_state_t state_q;
    logic [1:0] phase_q;
    logic [PC_W-1:0] pc_q;
    logic [7:0] w_q, status_q, pc_high_holding_latch_q, dir_q, port_q, timer_q;
    logic [PC_W-1:0] stack_q [STACK_DEPTH];
    logic flush_inc_q;
    logic [12:0] jump_target;
    mcuid_op_t op;
    logic is_watchdog_clear_op;
    logic [6:0] faddr;
    logic [2:0] bidx;
    logic [7:0] lit, fval, res;
    logic dest_f, wr_file, wr_w, set_z, set_c, set_dc, c_out, dc_out;
    logic skip, jump, ret, call, exec;
    logic [PC_W-1:0] pc_next;

    // Adder with carry and nibble carry, shared by add and subtract forms.
    function automatic logic [9:0] alu_add(input logic [7:0] a, input logic [7:0] b, input logic cin);
        logic [8:0] s;
        logic [4:0] n;
        s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        n = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        return {n[4], s};
    endfunction : alu_add

    mcuid_decode i_mcuid_decode (
        .i_instr(I_INSTR),
        .o_op(op),
        .o_is_watchdog_clear_op(is_watchdog_clear_op)
    );

    assign faddr = I_INSTR[6:0];
    // Upper target bits come from the holding latch; cut to the counter width below.
    assign jump_target = {pc_high_holding_latch_q[4:3], I_INSTR[10:0]};
    assign bidx = I_INSTR[9:7];
    assign lit = I_INSTR[7:0];
    assign dest_f = I_INSTR[7];
    // One instruction is executed per four-phase instruction cycle.
    assign exec = I_CE && phase_q == 2'd3 && state_q == MCUID_EXEC;

    // Source operand mux; special registers shadow the external file.
    always_comb begin
        if (faddr == `MCUID_ADDR_PCL) begin
            fval = pc_q[7:0];
        end else if (faddr == `MCUID_ADDR_STATUS) begin
            fval = status_q;
        end else if (faddr == `MCUID_ADDR_PC_HIGH_HOLDING_LATCH) begin
            fval = pc_high_holding_latch_q;
        end else if (faddr == `MCUID_ADDR_TIMER) begin
            fval = timer_q;
        end else if (faddr == `MCUID_ADDR_PORT) begin
            fval = I_PORT_PINS;
        end else begin
            fval = I_FILE_RDATA;
        end
    end

    // Result and flag computation.
    always_comb begin
        logic [9:0] sum;
        sum = 10'h000;
        res = fval;
        wr_file = 1'b0;
        wr_w = 1'b0;
        set_z = 1'b0;
        set_c = 1'b0;
        set_dc = 1'b0;
        c_out = status_q[`MCUID_ST_C];
        dc_out = status_q[`MCUID_ST_DC];
        skip = 1'b0;
        jump = 1'b0;
        ret = 1'b0;
        call = 1'b0;
        case (op)
            OP_MOVWF: begin res = w_q; wr_file = 1'b1; end
            OP_CLR: begin res = 8'h00; wr_file = dest_f; wr_w = !dest_f; set_z = 1'b1; end
            OP_ADD_W_FILE, OP_SUB_W_FILE, OP_ADD_LITERAL, OP_SUB_LITERAL: begin
                if (op == OP_ADD_W_FILE) sum = alu_add(fval, w_q, 1'b0);
                else if (op == OP_SUB_W_FILE) sum = alu_add(fval, ~w_q, 1'b1);
                else if (op == OP_ADD_LITERAL) sum = alu_add(lit, w_q, 1'b0);
                else sum = alu_add(lit, ~w_q, 1'b1);
                res = sum[7:0];
                c_out = sum[8];
                dc_out = sum[9];
                set_z = 1'b1;
                set_c = 1'b1;
                set_dc = 1'b1;
                wr_file = (op == OP_ADD_W_FILE || op == OP_SUB_W_FILE) && dest_f;
                wr_w = !wr_file;
            end
            OP_ANDWF, OP_OR_W_FILE, OP_XOR_W_FILE, OP_COMPLEMENT_FILE, OP_MOVF, OP_INCREMENT_FILE, OP_DECREMENT_FILE: begin
                if (op == OP_ANDWF) res = w_q & fval;
                else if (op == OP_OR_W_FILE) res = w_q | fval;
                else if (op == OP_XOR_W_FILE) res = w_q ^ fval;
                else if (op == OP_COMPLEMENT_FILE) res = ~fval;
                else if (op == OP_INCREMENT_FILE) res = fval + 8'h01;
                else if (op == OP_DECREMENT_FILE) res = fval - 8'h01;
                else res = fval;
                set_z = 1'b1;
                wr_file = dest_f;
                wr_w = !dest_f;
            end
            OP_DEC_SKIP_ZERO, OP_INC_SKIP_ZERO: begin
                res = (op == OP_INC_SKIP_ZERO) ? fval + 8'h01 : fval - 8'h01;
                skip = (res == 8'h00);
                wr_file = dest_f;
                wr_w = !dest_f;
            end
            OP_RLF, OP_RRF: begin
                res = (op == OP_RLF) ? {fval[6:0], status_q[`MCUID_ST_C]} : {status_q[`MCUID_ST_C], fval[7:1]};
                c_out = (op == OP_RLF) ? fval[7] : fval[0];
                set_c = 1'b1;
                wr_file = dest_f;
                wr_w = !dest_f;
            end
            OP_SWAPF: begin res = {fval[3:0], fval[7:4]}; wr_file = dest_f; wr_w = !dest_f; end
            OP_BCF, OP_BSF: begin
                res = fval;
                res[bidx] = (op == OP_BSF);
                wr_file = 1'b1;
            end
            OP_TEST_SKIP_CLEAR: skip = !fval[bidx];
            OP_TEST_SKIP_SET: skip = fval[bidx];
            OP_MOVE_LITERAL: begin res = lit; wr_w = 1'b1; end
            OP_RETURN_WITH_LITERAL: begin res = lit; wr_w = 1'b1; ret = 1'b1; end
            OP_OR_LITERAL: begin res = w_q | lit; wr_w = 1'b1; set_z = 1'b1; end
            OP_XOR_LITERAL: begin res = w_q ^ lit; wr_w = 1'b1; set_z = 1'b1; end
            OP_ANDLW: begin res = w_q & lit; wr_w = 1'b1; set_z = 1'b1; end
            OP_CALL: call = 1'b1;
            OP_JUMP_OP: jump = 1'b1;
            OP_RETURN: ret = 1'b1;
            default: res = fval;
        endcase
    end

    // Next program counter; a write to the low byte pulls in the holding latch.
    always_comb begin
        pc_next = pc_q + PC_W'(1);
        if (jump || call) begin
            pc_next = jump_target[PC_W-1:0];
        end else if (ret) begin
            pc_next = stack_q[0];
        end else if (wr_file && faddr == `MCUID_ADDR_PCL) begin
            pc_next = {pc_high_holding_latch_q[PC_W-9:0], res};
        end
    end

    // Phase counter divides the clock into instruction cycles.
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            phase_q <= 2'd0;
        end else if (I_CE) begin
            phase_q <= phase_q + 2'd1;
        end
    end

    // Second cycle of a branch or taken skip executes as a no-operation.
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            state_q <= MCUID_EXEC;
            flush_inc_q <= 1'b0;
        end else if (I_CE && phase_q == 2'd3) begin
            if (state_q == MCUID_FLUSH) begin
                state_q <= MCUID_EXEC;
            end else if (skip || jump || call || ret || (wr_file && faddr == `MCUID_ADDR_PCL)) begin
                state_q <= MCUID_FLUSH;
                // Only a skip steps past the discarded word; a branch must not pass its target.
                flush_inc_q <= skip && !(wr_file && faddr == `MCUID_ADDR_PCL);
            end
        end
    end

    // Program counter and return stack.
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            pc_q <= '0;
            for (int i = 0; i < STACK_DEPTH; i++) stack_q[i] <= '0;
        end else if (I_CE && phase_q == 2'd3) begin
            if (state_q == MCUID_FLUSH) begin
                if (flush_inc_q) begin
                    pc_q <= pc_q + PC_W'(1);
                end
            end else begin
                pc_q <= pc_next;
                if (call) begin
                    stack_q[0] <= pc_q + PC_W'(1);
                    for (int i = 1; i < STACK_DEPTH; i++) stack_q[i] <= stack_q[i-1];
                end else if (ret) begin
                    for (int i = 0; i < STACK_DEPTH - 1; i++) stack_q[i] <= stack_q[i+1];
                end
            end
        end
    end

    // Working register.
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            w_q <= 8'h00;
        end else if (exec && wr_w) begin
            w_q <= res;
        end
    end

    // Status: a file write lands first, then the instruction's own flags win.
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            status_q <= `MCUID_STATUS_RST;
        end else if (exec) begin
            logic [7:0] s;
            s = (wr_file && faddr == `MCUID_ADDR_STATUS) ? {res[7:5], status_q[4:3], res[2:0]} : status_q;
            if (set_z) s[`MCUID_ST_Z] = (res == 8'h00);
            if (set_c) s[`MCUID_ST_C] = c_out;
            if (set_dc) s[`MCUID_ST_DC] = dc_out;
            if (op == OP_SLEEP_WDT) begin
                s[`MCUID_ST_TO] = 1'b1;
                s[`MCUID_ST_PD] = is_watchdog_clear_op;
            end
            status_q <= s;
        end
    end

    // Holding latch, port latch and timer.
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            pc_high_holding_latch_q <= 8'h00;
            port_q <= 8'h00;
            timer_q <= 8'h00;
        end else if (exec && wr_file) begin
            if (faddr == `MCUID_ADDR_PC_HIGH_HOLDING_LATCH) pc_high_holding_latch_q <= res;
            if (faddr == `MCUID_ADDR_PORT) port_q <= res;
            if (faddr == `MCUID_ADDR_TIMER) timer_q <= res;
        end
    end

    // Direction register is loaded from W only by its own control word; bit 3 is forced at the output.
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            dir_q <= `MCUID_DIR_RST;
        end else if (exec && I_INSTR == `MCUID_DIR_LOAD_INSTR) begin
            dir_q <= w_q;
        end
    end

    // Event outputs: pulses in the executing phase.
    assign O_PRESCALER_CLR = exec && wr_file && faddr == `MCUID_ADDR_TIMER && I_PRESCALER_ON_TIMER;
    assign O_WDT_CLR = exec && op == OP_SLEEP_WDT;
    assign O_SLEEP = exec && op == OP_SLEEP_WDT && !is_watchdog_clear_op;
    assign O_INSTR_CYCLE = I_CE && phase_q == 2'd3;
    assign O_FLUSH = (state_q == MCUID_FLUSH);
    assign O_PC = pc_q;
    assign O_FILE_ADDR = faddr;
    assign O_FILE_WDATA = res;
    assign O_FILE_WE = exec && wr_file;
    assign O_W = w_q;
    assign O_STATUS = status_q;
    assign O_PORT_LATCH = port_q;
    assign O_PORT_DIR = dir_q | (8'h01 << `MCUID_INPUT_ONLY_BIT);
    assign O_TIMER = timer_q;

    a_flush_follows: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        (exec && (jump || call)) |=> state_q == MCUID_FLUSH)
        else $error("branch did not insert a no-operation cycle");
    a_dir_bit_set: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        O_PORT_DIR[3])
        else $error("input-only direction bit reads zero");
    a_prescaler_clr: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        O_PRESCALER_CLR |-> I_PRESCALER_ON_TIMER && faddr == `MCUID_ADDR_TIMER)
        else $error("prescaler cleared without timer write");
    a_skip_noflags: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        (exec && (op == OP_DEC_SKIP_ZERO || op == OP_INC_SKIP_ZERO) && !(wr_file && faddr == `MCUID_ADDR_STATUS))
        |=> $stable(status_q[2:0]))
        else $error("skip instruction changed a flag");
    a_zero_flag: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        (exec && set_z) |=> status_q[`MCUID_ST_Z] == ($past(res) == 8'h00))
        else $error("zero flag wrong");
    a_pcl_write: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        (exec && wr_file && faddr == `MCUID_ADDR_PCL) |=> pc_q[7:0] == $past(res))
        else $error("low pc byte not loaded");
    a_flush_one: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        (state_q == MCUID_FLUSH && I_CE && phase_q == 2'd3) |=> state_q == MCUID_EXEC)
        else $error("no-operation cycle longer than one");
    a_move_literal_w: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        (exec && op == OP_MOVE_LITERAL) |=> w_q == $past(lit))
        else $error("move literal did not load W");
    c_call: cover property (@(posedge I_CLK) exec && call);
    c_skip: cover property (@(posedge I_CLK) exec && skip);
    c_status_write: cover property (@(posedge I_CLK) exec && wr_file && faddr == `MCUID_ADDR_STATUS);
endmodule : mcuid_core

// ### verification/test_mcu_instruction_decode_sfr_rules.sv
`timescale 1ns/100ps
module test_mcu_instruction_decode_sfr_rules;
    import mcuid_pkg::*;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_ce = 1'b1;
    logic i_pre = 1'b0;
    logic [13:0] i_instr = 14'h0000;
    logic [7:0] i_pins = 8'h00;
    logic [7:0] i_rdata = 8'h00;
    logic [10:0] o_pc, pc_s;
    logic [6:0] o_addr, ad_s;
    logic [7:0] o_wdata, o_w, o_status, o_latch, o_dir, o_timer, wd_s;
    logic o_we, o_pclr, o_wdt, o_sleep, o_icyc, o_flush, we_s, pclr_s, wdt_s, slp_s;
    int miscompares = 0;
    int n_tests = 0;
    int nfl;
    // The core runs at 200 MHz.
    always #2.5 i_clk = ~i_clk;
    mcuid_core i_mcuid_core (.I_CLK(i_clk), .I_RESET_N(i_reset_n), .I_CE(i_ce), .I_INSTR(i_instr),
        .I_PORT_PINS(i_pins), .I_PRESCALER_ON_TIMER(i_pre), .I_FILE_RDATA(i_rdata), .O_PC(o_pc),
        .O_FILE_ADDR(o_addr), .O_FILE_WDATA(o_wdata), .O_FILE_WE(o_we), .O_W(o_w), .O_STATUS(o_status),
        .O_PORT_LATCH(o_latch), .O_PORT_DIR(o_dir), .O_TIMER(o_timer), .O_PRESCALER_CLR(o_pclr),
        .O_WDT_CLR(o_wdt), .O_SLEEP(o_sleep), .O_INSTR_CYCLE(o_icyc), .O_FLUSH(o_flush));
    // Compares one value and counts it.
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Runs one instruction; flush cycles met on the way are counted, pulses are caught before the edge.
    task automatic ex(input logic [13:0] ins, input logic [7:0] rd = 8'h00);
        int n;
        i_instr = ins;
        i_rdata = rd;
        nfl = 0;
        n = 0;
        while (!(o_icyc === 1'b1 && o_flush !== 1'b1) && n < 16) begin
            if (o_icyc === 1'b1) nfl++;
            @(negedge i_clk);
            n++;
        end
        chk(n < 16, 1'b1);
        {we_s, wd_s, ad_s, pc_s} = {o_we, o_wdata, o_addr, o_pc};
        {pclr_s, wdt_s, slp_s} = {o_pclr, o_wdt, o_sleep};
        @(negedge i_clk);
    endtask : ex
    // Reset values, with the input-only direction bit.
    task automatic t_reset();
        chk({o_pc, 5'h00}, 16'h0000);
        chk({o_w, o_status}, 16'h0018);
        chk(o_dir, 8'hff);
    endtask : t_reset
    // Clearing the status register still raises the zero flag.
    task automatic t_status();
        ex(14'h0183);
        chk(o_status, 8'h1c);
        ex(14'h3003);
        ex(14'h0083);
        chk(o_status, 8'h1b);
    endtask : t_status
    // Logic operations touch only zero; carry and digit carry stay set.
    task automatic t_logic();
        ex(14'h3a03);
        chk({o_w, o_status}, 16'h001f);
        ex(14'h3881);
        chk({o_w, o_status}, 16'h811b);
        ex(14'h0520, 8'h0f);
        chk({o_w, o_status}, 16'h011b);
        ex(14'h0420, 8'h80);
        chk({o_w, o_status}, 16'h811b);
        ex(14'h0620, 8'h81);
        chk({o_w, o_status}, 16'h001f);
        ex(14'h0920, 8'h00);
        chk({o_w, o_status}, 16'hff1b);
        ex(14'h305a);
        chk({o_w, o_status, nfl[7:0]}, 24'h5a1b00);
    endtask : t_logic
    // Adds and subtracts set all three arithmetic flags; destination bit steers the result.
    task automatic t_arith();
        ex(14'h30ff);
        ex(14'h3e01);
        chk({o_w, o_status & 8'h07}, 16'h0007);
        ex(14'h3001);
        ex(14'h3c00);
        chk({o_w, o_status & 8'h07}, 16'hff00);
        ex(14'h30ff);
        ex(14'h0720, 8'h01);
        chk({o_w, o_status & 8'h07}, 16'h0007);
        chk(we_s, 1'b0);
        ex(14'h0220, 8'h10);
        chk({o_w, o_status & 8'h07}, 16'h1003);
        ex(14'h07a0, 8'h05);
        chk({we_s, ad_s, wd_s}, {1'b1, 7'h20, 8'h15});
        chk(o_w, 8'h10);
    endtask : t_arith
    // Bit set and clear rewrite the whole byte; bit tests skip when true.
    task automatic t_bits();
        ex(14'h16a0, 8'h81);
        chk({we_s, ad_s, wd_s}, {1'b1, 7'h20, 8'ha1});
        ex(14'h13a0, 8'h81);
        chk({we_s, ad_s, wd_s}, {1'b1, 7'h20, 8'h01});
        ex(14'h1c20, 8'h01);
        ex(14'h1820, 8'h01);
        chk(nfl, 1);
        ex(14'h3000);
        chk(nfl, 0);
    endtask : t_bits
    // Skip forms leave the flags alone; plain increment and decrement move zero only.
    task automatic t_skip();
        logic [7:0] st;
        st = o_status;
        ex(14'h0ba0, 8'h01);
        chk({we_s, wd_s, o_status}, {1'b1, 8'h00, st});
        ex(14'h0f20, 8'hff);
        chk({nfl[7:0], o_w, o_status}, {8'h01, 8'h00, st});
        ex(14'h0320, 8'h01);
        chk({nfl[7:0], o_w, o_status}, {8'h01, 8'h00, st | 8'h04});
        ex(14'h0a20, 8'h01);
        chk({nfl[7:0], o_w, o_status}, {8'h00, 8'h02, st & 8'hfb});
    endtask : t_skip
    // Rotates pass through carry and leave zero alone even on a zero result.
    task automatic t_rot();
        ex(14'h3000);
        ex(14'h0083);
        ex(14'h0d20, 8'h80);
        chk({o_w, o_status}, 16'h0019);
        ex(14'h0c20, 8'h01);
        chk({o_w, o_status, nfl[7:0]}, 24'h801900);
    endtask : t_rot
    // Jumps, low program counter byte access, call and return.
    task automatic t_pc();
        logic [10:0] ra;
        ex(14'h2923);
        chk(o_pc, 11'h123);
        ex(14'h3001);
        chk(nfl, 1);
        chk(pc_s, 11'h123);
        ex(14'h008a);
        ex(14'h0802);
        chk(o_w, pc_s[7:0]);
        ex(14'h3040);
        ex(14'h0082);
        chk(o_pc, 11'h140);
        ex(14'h3002);
        chk(nfl, 1);
        ex(14'h0782);
        chk(o_pc, {3'h1, pc_s[7:0] + 8'h02});
        ex(14'h2050);
        chk(o_pc, 11'h050);
        ra = pc_s + 11'h001;
        ex(14'h3433);
        chk({nfl[7:0], o_w}, 16'h0133);
        chk(o_pc, ra);
        ex(14'h3000);
        chk(nfl, 1);
    endtask : t_pc
    // A timer write clears the prescaler only while it belongs to the timer.
    task automatic t_timer();
        i_pre = 1'b1;
        ex(14'h3077);
        ex(14'h0081);
        chk({7'h00, pclr_s, o_timer}, 16'h0177);
        i_pre = 1'b0;
        ex(14'h0081);
        chk(pclr_s, 1'b0);
    endtask : t_timer
    // A port rewritten from itself takes the pin levels.
    task automatic t_port();
        i_pins = 8'h5a;
        ex(14'h30a5);
        ex(14'h0086);
        chk(o_latch, 8'ha5);
        ex(14'h0886);
        chk(o_latch, 8'h5a);
        ex(14'h3000);
        ex(14'h0066);
        chk(o_dir, 8'h08);
    endtask : t_port
    // Four enabled clocks per instruction; a low enable stretches the cycle.
    task automatic t_cyc();
        int n;
        i_instr = 14'h0000;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            while (o_icyc !== 1'b1 && n < 20) begin
                @(negedge i_clk);
                n++;
            end
            n = 0;
            do begin
                i_ce = !(k == 1 && (n == 1 || n == 2));
                @(negedge i_clk);
                n++;
            end while (o_icyc !== 1'b1 && n < 20);
            chk(n, 4 + 2 * k);
        end
        i_ce = 1'b1;
        @(negedge i_clk);
    endtask : t_cyc
    // Watchdog clear and standby; standby last since the core may halt after it.
    task automatic t_pwr();
        ex(14'h0064);
        chk({wdt_s, o_status[4:3]}, 3'b111);
        ex(14'h0063);
        chk({slp_s, o_status[4:3]}, 3'b110);
    endtask : t_pwr
    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results
    // A hang is cut short well after the tests should have ended.
    initial begin
        #200000;
        miscompares++;
        results();
    end
    // Main sequence; inputs change at falling edges only.
    initial begin
        repeat (16) @(negedge i_clk);
        i_reset_n = 1'b1;
        t_reset();
        t_status();
        t_logic();
        t_arith();
        t_bits();
        t_skip();
        t_rot();
        t_pc();
        t_timer();
        t_port();
        t_cyc();
        t_pwr();
        results();
    end
endmodule : test_mcu_instruction_decode_sfr_rules
